// ---- logic/ltw_pkg.sv ----
// Constants, types and register map of the light threshold and wait logic.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
// Notes on behaviour
// R1: Wait pause is (count plus one) ticks.
// R2: Long-wait bit multiplies the pause by twelve.
// R3: Compare results against the 16-bit low threshold.
// R4: Compare results against the 16-bit high threshold.
// R5: Result below low threshold is out of range.
// R6: Result above high threshold is out of range.
// R7: Pin asserts when flag and enable set.
// R8: Low byte shadowed until high byte write.
// R9: Host writes low byte, then high byte.
// R10: Setting 0 every cycle, 1 any outlier.
// R11: Settings 2, 3 need that many outliers.
// R12: Settings 4-7, 13-15 need listed run lengths.
// R13: Settings 8-12 need 25 to 45 outliers.
// R14: Raise when run count equals the setting.
// R15: In-range result clears the run counter.
// R16: Host keeps reserved config-zero bits at defaults.
// R17: Wait, threshold, persistence registers reset zero.
// R18: Wait pause only while wait enable set.
// R19: Tick is 2048 integration clocks, oscillator/11.
// R20: Light flag is status bit 4.
// R21: Flags clear on write-one or on read; a status read clears only with read-clear set.
// R22: Interrupt pin is active low open drain.
package ltw_pkg;

   // Register offsets.
   localparam logic [7:0] ADDR_ENABLE = 8'h80;
   localparam logic [7:0] ADDR_WAIT_COUNT = 8'h83;
   localparam logic [7:0] ADDR_LOW_THR_LO = 8'h84;
   localparam logic [7:0] ADDR_LOW_THR_HI = 8'h85;
   localparam logic [7:0] ADDR_HIGH_THR_LO = 8'h86;
   localparam logic [7:0] ADDR_HIGH_THR_HI = 8'h87;
   localparam logic [7:0] ADDR_PERSIST = 8'h8C;
   localparam logic [7:0] ADDR_CONFIG_ZERO = 8'h8D;
   localparam logic [7:0] ADDR_STATUS = 8'h93;
   localparam logic [7:0] ADDR_CONFIG_THREE = 8'hAB;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hDD;

   // Values after reset.
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_CONFIG_ZERO = 8'h80;
   localparam logic [7:0] RST_CONFIG_THREE = 8'h0C;

   // Field positions.
   localparam int BIT_POWER_ON = 0;
   localparam int BIT_ALS_ENABLE = 1;
   localparam int BIT_WAIT_ENABLE = 3;
   localparam int BIT_LONG_WAIT = 2;
   localparam int BIT_LIGHT_FLAG = 4;
   localparam int BIT_READ_CLEAR = 7;
   localparam int BIT_LIGHT_IRQ_EN = 4;

   // Timing: one tick is 2048 integration clocks of oscillator/11.
   localparam int CLK_MHZ = 200;
   localparam int OSC_PERIOD_NS = 125;
   localparam int ICLK_DIV = 11;
   localparam int ICLK_CYCLES = (OSC_PERIOD_NS * ICLK_DIV * CLK_MHZ) / 1000;
   localparam int TICK_ICLKS_DEF = 2048;
   localparam logic [11:0] LONG_WAIT_FACTOR = 12'h00C;
   localparam logic [5:0] RUN_MAX = 6'h3F;

   // Bus address of the device; the value is arbitrary.
   localparam logic [6:0] DEV_ADDR_DEF = 7'h2A;

   // Serial bus slave states.
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_ACK = 6'h04,
      ST_RX = 6'h08,
      ST_TX = 6'h10,
      ST_RACK = 6'h20
   } ltw_bus_state_t;

   // Active threshold pair.
   typedef struct packed {
      logic [15:0] low;
      logic [15:0] high;
   } ltw_thr_t;

   // One visible-channel result.
   typedef struct packed {
      logic valid;
      logic [15:0] vis;
   } ltw_result_t;

endpackage : ltw_pkg

// ---- logic/ltw_wait.sv ----
// Wait timer between measurement cycles.
// Assumes start is a one-cycle pulse and run stays high during the pause.
`timescale 1ns/1ps
module ltw_wait
   import ltw_pkg::*;
#(
   parameter int TICK_ICLKS = TICK_ICLKS_DEF
)(
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Control.
   input wire logic start_in,
   input wire logic run_in,
   input wire logic [7:0] wait_count_in,
   input wire logic long_wait_x12_in,
   // Status.
   output logic busy_out,
   output logic done_out
);

   logic [8:0] presc_ff;
   logic [10:0] iclk_ff;
   logic [11:0] ticks_ff;
   logic [11:0] base;
   logic [11:0] total;
   logic tick_end;

   // Pause length in ticks, stretched twelve-fold in long mode.
   always_comb begin
      base = {4'h0, wait_count_in} + 12'h001; // R1
      total = long_wait_x12_in ? 12'(base * LONG_WAIT_FACTOR) : base; // R2
      tick_end = (presc_ff == 9'(ICLK_CYCLES - 1)) &&
                 (iclk_ff == 11'(TICK_ICLKS - 1)); // R19
   end

   // Down counter; the prescalers restart with each pause so the first
   // tick is full length rather than a fraction left over from before.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         presc_ff <= 9'h000;
         iclk_ff <= 11'h000;
         ticks_ff <= 12'h000;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (!run_in) begin
            busy_out <= 1'b0; // R18
         end else if (start_in) begin
            presc_ff <= 9'h000;
            iclk_ff <= 11'h000;
            ticks_ff <= total; // R1
            busy_out <= 1'b1;
         end else if (busy_out) begin
            if (presc_ff == 9'(ICLK_CYCLES - 1)) begin
               presc_ff <= 9'h000;
               iclk_ff <= tick_end ? 11'h000 : 11'(iclk_ff + 11'h001);
            end else begin
               presc_ff <= 9'(presc_ff + 9'h001);
            end
            if (tick_end) begin
               ticks_ff <= 12'(ticks_ff - 12'h001);
               if (ticks_ff == 12'h001) begin
                  busy_out <= 1'b0;
                  done_out <= 1'b1;
               end
            end
         end
      end
   end

endmodule : ltw_wait

// ---- logic/ltw_persist.sv ----
// Threshold compare and persistence filter for visible-channel results.
// Assumes one valid pulse per finished measurement cycle.
`timescale 1ns/1ps
module ltw_persist
   import ltw_pkg::*;
(
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Result and settings.
   input wire ltw_result_t res_in,
   input wire ltw_thr_t thr_in,
   input wire logic [3:0] persist_select_in,
   // Event.
   output logic raise_out
);

   logic [5:0] run_ff;
   logic [5:0] run_next;
   logic out_of_range;

   // Run length a setting asks for: 2, 3, then steps of five.
   function automatic logic [5:0] need_run(input logic [3:0] sel);
      logic [5:0] s;
      s = {2'h0, sel};
      if (sel < 4'h4) begin
         need_run = s; // R11
      end else begin
         need_run = 6'((s - 6'h03) * 6'h05); // R12 R13
      end
   endfunction : need_run

   // The run counter saturates so a long outlier run cannot wrap around
   // and fire a second, spurious match.
   always_comb begin
      out_of_range = (res_in.vis < thr_in.low) || // R3 R5
                     (res_in.vis > thr_in.high); // R4 R6
      run_next = (run_ff == RUN_MAX) ? RUN_MAX : 6'(run_ff + 6'h01);
   end

   // Count consecutive outliers and raise on the programmed count.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         run_ff <= 6'h00;
         raise_out <= 1'b0;
      end else begin
         raise_out <= 1'b0;
         if (res_in.valid) begin
            if (!out_of_range) begin
               run_ff <= 6'h00; // R15
               raise_out <= (persist_select_in == 4'h0); // R10
            end else begin
               run_ff <= run_next;
               raise_out <= (persist_select_in < 4'h2) || // R10
                  (run_next == need_run(persist_select_in)); // R14
            end
         end
      end
   end

endmodule : ltw_persist

// ---- logic/ltw_top.sv ----
// Top of the light threshold and wait logic: serial bus slave, register
// file, measurement sequencing, interrupt flag and open-drain pin.
// Assumes the converter delivers results on the same clock, and that the
// serial bus pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
module ltw_top
   import ltw_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF, // Value is arbitrary.
   parameter int TICK_ICLKS = TICK_ICLKS_DEF
)(
   // Clock and reset.
   input wire logic MCLK_IN,
   input wire logic SYS_RST_IN,
   // Two-wire serial bus.
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_N_OUT,
   // Visible-channel results.
   input wire logic [15:0] VIS_DATA_IN,
   input wire logic VIS_VALID_IN,
   // Measurement sequencing.
   output logic POWER_ON_OUT,
   output logic ALS_ENABLE_OUT,
   output logic ALS_START_OUT,
   output logic WAIT_ACTIVE_OUT,
   // Interrupt pin.
   output logic INT_OUT,
   output logic INT_OE_N_OUT
);

   // Pin synchronisers and filtered levels.
   logic [2:0] scl_sync_ff;
   logic [2:0] sda_sync_ff;
   logic scl_ff;
   logic sda_ff;
   logic scl_prev_ff;
   logic sda_prev_ff;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;

   // Bus slave state.
   ltw_bus_state_t state_ff;
   logic [2:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic [7:0] ptr_ff;
   logic ptr_phase_ff;
   logic rw_ff;
   logic byte_full_ff;
   logic sda_oe_n_ff;
   logic wr_stb_ff;
   logic [7:0] wr_addr_ff;
   logic [7:0] wr_data_ff;
   logic rd_stb_ff;
   logic [7:0] rd_addr_ff;
   logic [7:0] rd_data;

   // Registers.
   logic [7:0] enable_ff;
   logic [7:0] wait_count_ff;
   logic [7:0] persistence_filter_ff;
   logic [7:0] config_zero_ff;
   logic [7:0] config_three_ff;
   logic [7:0] irq_enable_ff;
   logic [7:0] low_thr_shadow_ff;
   logic [7:0] high_thr_shadow_ff;
   ltw_thr_t thr_ff;
   logic light_threshold_flag_ff;
   logic flag_clear;

   // Sequencing.
   logic als_on;
   logic als_on_prev_ff;
   logic wait_busy;
   logic wait_done;
   logic persist_raise;
   ltw_result_t res;

   // Three flops per pin; a level is taken only when stages two and
   // three agree, which filters single-sample glitches on the bus.
   always_ff @(posedge MCLK_IN) begin
      if (SYS_RST_IN) begin
         scl_sync_ff <= 3'h7;
         sda_sync_ff <= 3'h7;
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end else begin
         scl_sync_ff <= {scl_sync_ff[1:0], SCL_IN};
         sda_sync_ff <= {sda_sync_ff[1:0], SDA_IN};
         if (scl_sync_ff[1] == scl_sync_ff[2]) begin
            scl_ff <= scl_sync_ff[2];
         end
         if (sda_sync_ff[1] == sda_sync_ff[2]) begin
            sda_ff <= sda_sync_ff[2];
         end
         scl_prev_ff <= scl_ff;
         sda_prev_ff <= sda_ff;
      end
   end

   // Bus events from the filtered levels.
   assign scl_rise = scl_ff & ~scl_prev_ff;
   assign scl_fall = ~scl_ff & scl_prev_ff;
   assign start_cond = scl_ff & scl_prev_ff & sda_prev_ff & ~sda_ff;
   assign stop_cond = scl_ff & scl_prev_ff & ~sda_prev_ff & sda_ff;

   // Read-back mux; unmapped offsets read zero.
   always_comb begin
      case (ptr_ff)
         ADDR_ENABLE: rd_data = enable_ff;
         ADDR_WAIT_COUNT: rd_data = wait_count_ff;
         ADDR_LOW_THR_LO: rd_data = low_thr_shadow_ff;
         ADDR_LOW_THR_HI: rd_data = thr_ff.low[15:8];
         ADDR_HIGH_THR_LO: rd_data = high_thr_shadow_ff;
         ADDR_HIGH_THR_HI: rd_data = thr_ff.high[15:8];
         ADDR_PERSIST: rd_data = persistence_filter_ff;
         ADDR_CONFIG_ZERO: rd_data = config_zero_ff;
         ADDR_STATUS: rd_data = {3'h0, light_threshold_flag_ff, 4'h0}; // R20
         ADDR_CONFIG_THREE: rd_data = config_three_ff;
         ADDR_IRQ_ENABLE: rd_data = irq_enable_ff;
         default: rd_data = 8'h00;
      endcase
   end

   // Serial bus slave. Sampling is on rising clock edges and the data
   // line is changed only after falling edges, so setup and hold on the
   // line are left to the host's own clock timing.
   always_ff @(posedge MCLK_IN) begin
      if (SYS_RST_IN) begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= 3'h0;
         shift_ff <= 8'h00;
         ptr_ff <= 8'h00;
         ptr_phase_ff <= 1'b1;
         rw_ff <= 1'b0;
         byte_full_ff <= 1'b0;
         sda_oe_n_ff <= 1'b1;
         wr_stb_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         wr_data_ff <= 8'h00;
         rd_stb_ff <= 1'b0;
         rd_addr_ff <= 8'h00;
      end else begin
         wr_stb_ff <= 1'b0;
         rd_stb_ff <= 1'b0;
         if (start_cond) begin
            state_ff <= ST_ADDR;
            bit_cnt_ff <= 3'h0;
            byte_full_ff <= 1'b0;
            ptr_phase_ff <= 1'b1;
            sda_oe_n_ff <= 1'b1;
         end else if (stop_cond) begin
            state_ff <= ST_IDLE;
            sda_oe_n_ff <= 1'b1;
         end else begin
            case (state_ff)
               ST_ADDR, ST_RX: begin
                  if (scl_rise) begin
                     shift_ff <= {shift_ff[6:0], sda_ff};
                     bit_cnt_ff <= 3'(bit_cnt_ff + 3'h1);
                     byte_full_ff <= (bit_cnt_ff == 3'h7);
                  end else if (scl_fall && byte_full_ff) begin
                     byte_full_ff <= 1'b0;
                     if (state_ff == ST_ADDR) begin
                        if (shift_ff[7:1] == DEV_ADDR) begin
                           rw_ff <= shift_ff[0];
                           sda_oe_n_ff <= 1'b0;
                           state_ff <= ST_ACK;
                        end else begin
                           state_ff <= ST_IDLE;
                        end
                     end else begin
                        sda_oe_n_ff <= 1'b0;
                        state_ff <= ST_ACK;
                        if (ptr_phase_ff) begin
                           ptr_ff <= shift_ff;
                           ptr_phase_ff <= 1'b0;
                        end else begin
                           wr_stb_ff <= 1'b1;
                           wr_addr_ff <= ptr_ff;
                           wr_data_ff <= shift_ff;
                           ptr_ff <= 8'(ptr_ff + 8'h01);
                        end
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     bit_cnt_ff <= 3'h0;
                     if (rw_ff) begin
                        shift_ff <= rd_data;
                        sda_oe_n_ff <= rd_data[7];
                        rd_stb_ff <= 1'b1;
                        rd_addr_ff <= ptr_ff;
                        ptr_ff <= 8'(ptr_ff + 8'h01);
                        state_ff <= ST_TX;
                     end else begin
                        sda_oe_n_ff <= 1'b1;
                        state_ff <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_rise) begin
                     bit_cnt_ff <= 3'(bit_cnt_ff + 3'h1);
                     byte_full_ff <= (bit_cnt_ff == 3'h7);
                  end else if (scl_fall) begin
                     if (byte_full_ff) begin
                        byte_full_ff <= 1'b0;
                        sda_oe_n_ff <= 1'b1;
                        state_ff <= ST_RACK;
                     end else begin
                        shift_ff <= {shift_ff[6:0], 1'b0};
                        sda_oe_n_ff <= shift_ff[6];
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     if (sda_ff) begin
                        state_ff <= ST_IDLE; // Host ended the read.
                     end else begin
                        byte_full_ff <= 1'b1;
                     end
                  end else if (scl_fall && byte_full_ff) begin
                     byte_full_ff <= 1'b0;
                     bit_cnt_ff <= 3'h0;
                     shift_ff <= rd_data;
                     sda_oe_n_ff <= rd_data[7];
                     rd_stb_ff <= 1'b1;
                     rd_addr_ff <= ptr_ff;
                     ptr_ff <= 8'(ptr_ff + 8'h01);
                     state_ff <= ST_TX;
                  end
               end
               ST_IDLE: begin
                  sda_oe_n_ff <= 1'b1;
               end
               default: begin
                  state_ff <= ST_IDLE;
                  sda_oe_n_ff <= 1'b1;
               end
            endcase
         end
      end
   end

   // Plain control registers, stored as written; the host keeps the
   // reserved config-zero pattern itself (R16), nothing is forced here.
   always_ff @(posedge MCLK_IN) begin
      if (SYS_RST_IN) begin
         enable_ff <= RST_ZERO;
         wait_count_ff <= RST_ZERO; // R17
         persistence_filter_ff <= RST_ZERO; // R17
         config_zero_ff <= RST_CONFIG_ZERO;
         config_three_ff <= RST_CONFIG_THREE;
         irq_enable_ff <= RST_ZERO;
      end else if (wr_stb_ff) begin
         case (wr_addr_ff)
            ADDR_ENABLE: enable_ff <= wr_data_ff;
            ADDR_WAIT_COUNT: wait_count_ff <= wr_data_ff;
            ADDR_PERSIST: persistence_filter_ff <= wr_data_ff;
            ADDR_CONFIG_ZERO: config_zero_ff <= wr_data_ff;
            ADDR_CONFIG_THREE: config_three_ff <= wr_data_ff;
            ADDR_IRQ_ENABLE: irq_enable_ff <= wr_data_ff;
            default: ;
         endcase
      end
   end

   // Thresholds: the low byte waits in a shadow so the comparator never
   // sees a half-updated 16-bit value. A low-byte write without its
   // high byte changes nothing active (R9 is the host's duty).
   always_ff @(posedge MCLK_IN) begin
      if (SYS_RST_IN) begin
         low_thr_shadow_ff <= RST_ZERO; // R17
         high_thr_shadow_ff <= RST_ZERO; // R17
         thr_ff <= '0; // R17
      end else if (wr_stb_ff) begin
         case (wr_addr_ff)
            ADDR_LOW_THR_LO: low_thr_shadow_ff <= wr_data_ff; // R8
            ADDR_LOW_THR_HI: thr_ff.low <= {wr_data_ff, low_thr_shadow_ff};
            ADDR_HIGH_THR_LO: high_thr_shadow_ff <= wr_data_ff; // R8
            ADDR_HIGH_THR_HI: begin
               thr_ff.high <= {wr_data_ff, high_thr_shadow_ff}; // R8
            end
            default: ;
         endcase
      end
   end

   // Flag clear by write-one, or by a status read in read-clear mode.
   always_comb begin
      flag_clear = (wr_stb_ff && (wr_addr_ff == ADDR_STATUS) &&
                    wr_data_ff[BIT_LIGHT_FLAG]) || // R21
                   (rd_stb_ff && (rd_addr_ff == ADDR_STATUS) &&
                    config_three_ff[BIT_READ_CLEAR]); // R21
   end

   // Sticky light flag; a new event in the clearing cycle wins.
   always_ff @(posedge MCLK_IN) begin
      if (SYS_RST_IN) begin
         light_threshold_flag_ff <= 1'b0;
      end else begin
         light_threshold_flag_ff <= persist_raise | // R5 R6
            (light_threshold_flag_ff & ~flag_clear); // R21
      end
   end

   // Open-drain interrupt: pull low only while flag and enable are set.
   always_ff @(posedge MCLK_IN) begin
      if (SYS_RST_IN) begin
         INT_OUT <= 1'b0;
         INT_OE_N_OUT <= 1'b1;
      end else begin
         INT_OUT <= 1'b0; // R22
         INT_OE_N_OUT <= ~(light_threshold_flag_ff &
                           irq_enable_ff[BIT_LIGHT_IRQ_EN]); // R7 R22
      end
   end

   // Results count only while powered and measuring.
   assign als_on = enable_ff[BIT_POWER_ON] & enable_ff[BIT_ALS_ENABLE];
   assign res.valid = VIS_VALID_IN & als_on;
   assign res.vis = VIS_DATA_IN;

   // Next-cycle request: on switch-on, straight after a result when no
   // pause is wanted, or when the pause runs out.
   always_ff @(posedge MCLK_IN) begin
      if (SYS_RST_IN) begin
         als_on_prev_ff <= 1'b0;
         ALS_START_OUT <= 1'b0;
         POWER_ON_OUT <= 1'b0;
         ALS_ENABLE_OUT <= 1'b0;
         SDA_OUT <= 1'b0;
         SDA_OE_N_OUT <= 1'b1;
      end else begin
         als_on_prev_ff <= als_on;
         ALS_START_OUT <= (als_on & ~als_on_prev_ff) |
            (res.valid & ~enable_ff[BIT_WAIT_ENABLE]) | // R18
            (als_on & wait_done);
         POWER_ON_OUT <= enable_ff[BIT_POWER_ON];
         ALS_ENABLE_OUT <= als_on;
         SDA_OUT <= 1'b0;
         SDA_OE_N_OUT <= sda_oe_n_ff;
      end
   end

   // Pause timer between cycles.
   ltw_wait #(
      .TICK_ICLKS(TICK_ICLKS)
   ) u_wait (
      .clk_in(MCLK_IN),
      .rst_in(SYS_RST_IN),
      .start_in(res.valid),
      .run_in(als_on & enable_ff[BIT_WAIT_ENABLE]), // R18
      .wait_count_in(wait_count_ff),
      .long_wait_x12_in(config_zero_ff[BIT_LONG_WAIT]), // R2
      .busy_out(wait_busy),
      .done_out(wait_done)
   );

   assign WAIT_ACTIVE_OUT = wait_busy;

   // Threshold compare and persistence.
   ltw_persist u_persist (
      .clk_in(MCLK_IN),
      .rst_in(SYS_RST_IN),
      .res_in(res),
      .thr_in(thr_ff),
      .persist_select_in(persistence_filter_ff[3:0]),
      .raise_out(persist_raise)
   );

endmodule : ltw_top

// ---- tb/ltw_chk.sv ----
// Port checker for the light threshold and wait top.
// Assumes it is bound to the top and sees only its ports.
`timescale 1ns/1ps
module ltw_chk (
   // Clock, reset and result strobe.
   input wire logic MCLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic VIS_VALID_IN,
   // Outputs under watch.
   input wire logic POWER_ON_OUT,
   input wire logic ALS_ENABLE_OUT,
   input wire logic ALS_START_OUT,
   input wire logic WAIT_ACTIVE_OUT,
   input wire logic INT_OUT,
   input wire logic SDA_OUT,
   input wire logic INT_OE_N_OUT
);
   // One clock domain.
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   // A pause closes, then one launch pulse follows.
   sequence s_wait_end;
      $fell(WAIT_ACTIVE_OUT) && ALS_ENABLE_OUT;
   endsequence
   sequence s_launch;
      ##[0:2] ALS_START_OUT ##1 !ALS_START_OUT;
   endsequence
   AST_INT_LEVEL: assert property (!INT_OUT && !SDA_OUT)
      else $error("drive level not low");
   AST_PIN_FREE: assert property ($fell(SYS_RST_IN) |-> INT_OE_N_OUT)
      else $error("pin driven after reset");
   AST_PIN_CAUSE: assert property ($fell(INT_OE_N_OUT) |->
      $past(VIS_VALID_IN, 3)) else $error("pin asserted without result");
   AST_WAIT_END: assert property (s_wait_end |-> s_launch)
      else $error("no launch after pause");
   AST_NO_LAUNCH: assert property (WAIT_ACTIVE_OUT |-> !ALS_START_OUT)
      else $error("launch during pause");
   AST_WAIT_MIN: assert property ($rose(WAIT_ACTIVE_OUT) |->
      WAIT_ACTIVE_OUT[*8]) else $error("pause too short");
   AST_WAIT_GATE: assert property (!POWER_ON_OUT[*3] |->
      !WAIT_ACTIVE_OUT) else $error("pause while powered down");
   AST_WAIT_CAUSE: assert property ($rose(WAIT_ACTIVE_OUT) |->
      $past(VIS_VALID_IN) || $past(VIS_VALID_IN, 2))
      else $error("pause without result");
endmodule : ltw_chk

// ---- tb/ltw_host.sv ----
// Two-wire bus host model: drives the clock, pulls data low or releases.
// Assumes a pull-up on data and the block's open-drain enable.
`timescale 1ns/1ps
module ltw_host
   import ltw_pkg::*;
(
   // Clock and the block's data drive.
   input wire logic clk_in,
   input wire logic sda_oe_n_in,
   // Bus lines.
   output logic scl_out,
   output logic sda_out
);
   logic sda_pull = 1'b0;
   // Wired-and with a pull-up: a released line reads high.
   assign sda_out = !sda_pull && sda_oe_n_in;
   initial scl_out = 1'b1;
   task automatic hp();
      repeat (8) @(negedge clk_in);
   endtask : hp
   // Data moves only mid-way through the low phase.
   task automatic bt(input logic b, output logic r);
      sda_pull = !b;
      hp();
      scl_out = 1'b1;
      hp();
      r = sda_out;
      scl_out = 1'b0;
      hp();
   endtask : bt
   // Start when go is set, stop otherwise.
   task automatic cond(input logic go);
      sda_pull = !go;
      hp();
      scl_out = 1'b1;
      hp();
      sda_pull = go;
      hp();
      scl_out = !go;
      hp();
   endtask : cond
   task automatic byt(input logic [7:0] v, output logic [7:0] d,
      output logic nak);
      for (int i = 7; i >= 0; i--) bt(v[i], d[i]);
      bt(1'b1, nak);
   endtask : byt
   task automatic wr(input logic [7:0] a, dat, output logic nak);
      logic [7:0] x;
      logic n1;
      logic n2;
      cond(1'b1);
      byt({DEV_ADDR_DEF, 1'b0}, x, n1);
      byt(a, x, n2);
      byt(dat, x, nak);
      cond(1'b0);
      nak = nak | n1 | n2;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] x;
      logic n;
      cond(1'b1);
      byt({DEV_ADDR_DEF, 1'b0}, x, n);
      byt(a, x, n);
      cond(1'b1);
      byt({DEV_ADDR_DEF, 1'b1}, x, n);
      byt(8'hFF, d, n);
      cond(1'b0);
   endtask : rd
endmodule : ltw_host

// ---- tb/test_ltw_top.sv ----
// Self-checking bench for the light threshold and wait top.
// Assumes the host model and the checker of this folder.
`timescale 1ns/1ps
module test_ltw_top;
   import ltw_pkg::*;
   localparam int TK = 2;
   logic clk = 1'b0, rst = 1'b1, vv = 1'b0;
   logic [15:0] vd = 16'h0000;
   logic scl, sda, oe_n, int_n, wa, ak;
   logic [7:0] rv, ex;
   logic [7:0] q[$];
   int failures = 0, total_checks = 0, wcnt = 0, n;
   event got;
`define CMP(nm, e, s) begin total_checks++; if ((e) !== (s)) begin \
failures++; $display("wrong value %s exp %h seen %h", nm, e, s); end end
   always #2.5 clk = !clk;
   ltw_top #(.DEV_ADDR(DEV_ADDR_DEF), .TICK_ICLKS(TK)) DUT (
      .MCLK_IN(clk), .SYS_RST_IN(rst), .SCL_IN(scl), .SDA_IN(sda),
      .SDA_OUT(), .SDA_OE_N_OUT(oe_n), .VIS_DATA_IN(vd),
      .VIS_VALID_IN(vv), .POWER_ON_OUT(), .ALS_ENABLE_OUT(),
      .ALS_START_OUT(), .WAIT_ACTIVE_OUT(wa), .INT_OUT(),
      .INT_OE_N_OUT(int_n));
   ltw_host host (.clk_in(clk), .sda_oe_n_in(oe_n), .scl_out(scl),
      .sda_out(sda));
   task automatic wr(input logic [7:0] a, d);
      host.wr(a, d, ak);
      `CMP("ack", 1'b0, ak)
   endtask : wr
   // Reads are noted first and compared on arrival.
   task automatic rd(input logic [7:0] a, e);
      q.push_back(e);
      host.rd(a, rv);
      ->got;
   endtask : rd
   task automatic res(input logic [15:0] v);
      vd = v;
      vv = 1'b1;
      @(negedge clk);
      vv = 1'b0;
      repeat (5) @(negedge clk);
   endtask : res
   function automatic logic [15:0] out_val();
      if ($urandom_range(1) == 0) return 16'($urandom_range(16'h00FF));
      return 16'($urandom_range(16'h02FE, 16'h0201));
   endfunction : out_val
   // Oldest note against the byte just read.
   always @(got) begin
      ex = q.pop_front();
      `CMP("register", ex, rv)
   end
   // Pause length in clocks.
   always @(posedge clk) if (wa === 1'b1) wcnt++;
   task automatic complete_run();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run
   // A clean run needs about 78000 clocks.
   initial begin
      repeat (95000) @(posedge clk);
      failures++;
      complete_run();
   end
   // Main sequence.
   initial begin
      void'($urandom(98));
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (8) @(negedge clk);
      for (int a = 8'h83; a < 8'h88; a++) rd(8'(a), RST_ZERO);
      rd(ADDR_PERSIST, RST_ZERO);
      rd(ADDR_CONFIG_ZERO, RST_CONFIG_ZERO);
      rd(8'h88, 8'h00);
      n = $urandom_range(255);
      wr(ADDR_WAIT_COUNT, 8'(n));
      rd(ADDR_WAIT_COUNT, 8'(n));
      wr(ADDR_LOW_THR_LO, 8'h00);
      wr(ADDR_LOW_THR_HI, 8'h01);
      wr(ADDR_HIGH_THR_LO, 8'h00);
      wr(ADDR_HIGH_THR_HI, 8'h02);
      wr(ADDR_HIGH_THR_LO, 8'hFF);
      rd(ADDR_HIGH_THR_HI, 8'h02);
      wr(ADDR_IRQ_ENABLE, 8'h10);
      wr(ADDR_ENABLE, 8'h03);
      wcnt = 0;
      for (int s = 0; s < 16; s++) begin
         n = (s < 4) ? s : (s - 3) * 5;
         wr(ADDR_PERSIST, 8'(s));
         res(16'h0100);
         wr(ADDR_STATUS, 8'h10);
         `CMP("pin", 1'b1, int_n)
         if (s > 0) begin
            repeat (n - 1) res(out_val());
            res(16'h0100);
            repeat (n - 1) res(out_val());
            `CMP("pin", 1'b1, int_n)
         end
         res(s == 0 ? 16'h0200 : out_val());
         `CMP("pin", 1'b0, int_n)
         rd(ADDR_STATUS, 8'h10);
      end
      wr(ADDR_CONFIG_THREE, 8'h8C);
      rd(ADDR_STATUS, 8'h10);
      rd(ADDR_STATUS, 8'h00);
      `CMP("idle pause", 0, wcnt)
      wr(ADDR_WAIT_COUNT, 8'h01);
      wr(ADDR_ENABLE, 8'h0B);
      for (int lg = 1; lg >= 0; lg--) begin
         wr(ADDR_CONFIG_ZERO, lg ? 8'h84 : 8'h80);
         wcnt = 0;
         res(16'h0150);
         n = 2 * (lg ? 12 : 1) * ICLK_CYCLES * TK;
         for (int i = 0; i < 30000 && wa !== 1'b0; i++) @(negedge clk);
         `CMP("pause", 1'b1, wcnt >= n - 3 && wcnt <= n + 3)
      end
      complete_run();
   end
endmodule : test_ltw_top
bind ltw_top ltw_chk u_chk (.MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN),
   .VIS_VALID_IN(VIS_VALID_IN), .POWER_ON_OUT(POWER_ON_OUT),
   .ALS_ENABLE_OUT(ALS_ENABLE_OUT), .ALS_START_OUT(ALS_START_OUT),
   .WAIT_ACTIVE_OUT(WAIT_ACTIVE_OUT), .INT_OUT(INT_OUT),
   .INT_OE_N_OUT(INT_OE_N_OUT), .SDA_OUT(SDA_OUT));
